// *** pkg/scc_defs.svh ***
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH
`define SCC_ADDR_B03      8'h03
`define SCC_ADDR_B10      8'h0A
`define SCC_ADDR_B11      8'h0B
`define SCC_ADDR_B24      8'h18
`define SCC_ADDR_B25      8'h19
`define SCC_ADDR_B26      8'h1A
`define SCC_BIT_BYPASS    6
`define SCC_BIT_LOCK      7
`define SCC_BIT_NVWR      7
`define SCC_BIT_NVBUSY    7
`define SCC_BIT_INSEL     4
`define SCC_SSC_MSB       6
`define SCC_SSC_LSB       4
`define SCC_FAC_MSB       3
`define SCC_FAC_LSB       0
`define SCC_CNT_MSB       6
`define SCC_SRC_MSB       7
`define SCC_SRC_LSB       6
`define SCC_PINSEL_MSB    1
`define SCC_PINSEL_LSB    0
`define SCC_SSC_BYPASS    3'h0
`define SCC_RST_B03       8'h00
`define SCC_RST_B10       8'h00
`define SCC_RST_B11       8'h00
`define SCC_RST_B25       8'h09
`define SCC_RST_B26       8'h1B
`define SCC_CNT_ZERO      7'h00
`define SCC_PINSEL_CODE   2'h1
`define SCC_SRC_XTAL      2'h0
`define SCC_SRC_SE_A      2'h1
`define SCC_SRC_SE_B      2'h2
`define SCC_SRC_DIFF      2'h3
`define SCC_NV_TIME_US    20
`define SCC_CLK_MHZ       40
`define SCC_NV_CYCLES     (`SCC_NV_TIME_US * `SCC_CLK_MHZ)
`define SCC_NVCNT_W       16
`endif

// *** pkg/scc_pkg.sv ***
package scc_pkg;
  typedef enum logic [2:0] {
    SCC_NV_IDLE = 3'h1,
    SCC_NV_PROG = 3'h2,
    SCC_NV_DONE = 3'h4
  } scc_nv_state_e;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scc_req_s;
  typedef struct packed {
    logic       center;
    logic       down;
    logic       active;
    logic [1:0] step;
  } scc_spread_s;
endpackage : scc_pkg

// *** rtl/scc_cfg_regs.sv ***
`timescale 1ns/1ps
`include "scc_defs.svh"
// Contract
// - Spread codes 1-3 select center spread 0.1, 0.25, 0.4 percent; field bits 6:4.
// - Spread codes 4-7 select down spread 1, 1.5, 2, 3 percent.
// - Code zero bypasses spread; SPREAD active, center and down held low (step reads 3), normal output runs.
// - Lock bit blocks nonvolatile programming until SYS_RST; clearing the bit never reopens it.
// - After lock, writes still update working registers immediately.
// - Seven-bit count sets block read length; zero not allowed; default 27.
// - Nonvolatile write starts only on zero-to-one edge of command bit.
// - Command bit keeps host value; device never clears it.
// - Busy status readable at byte 24 bit 7.
// - Edge while locked starts no programming.
// - Byte 11 bits 7:6 pick crystal, two single-ended, or differential.
// - Byte 10 bit 4 picks single-ended input, input a by default.
// - Byte 10 bits 1:0 can hand input select to shared control pin.
// - Busy goes high at programming start, low at end; writes ignored.
module scc_cfg_regs (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       CE,
  input  wire logic       REQ_VALID,
  input  scc_pkg::scc_req_s REQ,
  input  wire logic       SHARED_CONTROL_PIN,
  output logic [7:0]      RDATA,
  output logic [6:0]      BLOCK_READ_COUNT,
  output logic            NV_WRITE_IN_PROGRESS,
  output logic            NV_PROG_STROBE,
  output logic            NV_PERMANENT_LOCK,
  output logic            LOOP_BYPASS,
  output logic [3:0]      MOD_FACTOR,
  output scc_pkg::scc_spread_s SPREAD,
  output logic [1:0]      INPUT_SOURCE,
  output logic            SEL_REF_INPUT_B
);
  logic [7:0] byte03;
  logic [7:0] byte10;
  logic [7:0] byte11;
  logic [7:0] byte25;
  logic [7:0] byte26;
  logic       lock_sticky;
  logic       wr_hit26;
  logic       nv_start;
  logic [`SCC_NVCNT_W-1:0] nv_cnt;
  scc_pkg::scc_nv_state_e  nv_state;
  logic [2:0] spread_amount_code;
  logic [`SCC_CNT_MSB:0] count_field;
  logic [3:0] factor_field;
  logic [1:0] src_field;
  logic [1:0] pinsel_field;
  logic       single_ended;
  localparam logic [`SCC_NVCNT_W-1:0] NV_LAST = `SCC_NVCNT_W'(`SCC_NV_CYCLES - 1);
  // Writes during programming are dropped to protect the array image
  wire wr_ok = CE && REQ_VALID && REQ.wr && (nv_state != scc_pkg::SCC_NV_PROG);
  assign wr_hit26 = wr_ok && (REQ.addr == `SCC_ADDR_B26);
  assign nv_start = wr_hit26 && REQ.wdata[`SCC_BIT_NVWR] && !byte26[`SCC_BIT_NVWR]
                    && !lock_sticky && !byte25[`SCC_BIT_LOCK];
  assign spread_amount_code = byte25[`SCC_SSC_MSB:`SCC_SSC_LSB];
  assign count_field        = byte26[`SCC_CNT_MSB:0];
  assign factor_field       = byte25[`SCC_FAC_MSB:`SCC_FAC_LSB];
  assign src_field          = byte11[`SCC_SRC_MSB:`SCC_SRC_LSB];
  assign pinsel_field       = byte10[`SCC_PINSEL_MSB:`SCC_PINSEL_LSB];
  assign single_ended       = (src_field == `SCC_SRC_SE_A) || (src_field == `SCC_SRC_SE_B);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      byte03 <= `SCC_RST_B03;
      byte10 <= `SCC_RST_B10;
      byte11 <= `SCC_RST_B11;
      byte25 <= `SCC_RST_B25;
      byte26 <= `SCC_RST_B26;
    end else if (wr_ok) begin
      case (REQ.addr)
        `SCC_ADDR_B03: byte03 <= REQ.wdata;
        `SCC_ADDR_B10: byte10 <= REQ.wdata;
        `SCC_ADDR_B11: byte11 <= REQ.wdata;
        `SCC_ADDR_B25: byte25 <= REQ.wdata;
        // Zero count is refused so a block read always returns data
        `SCC_ADDR_B26: byte26 <= (REQ.wdata[`SCC_CNT_MSB:0] == `SCC_CNT_ZERO) ?
                                 {REQ.wdata[`SCC_BIT_NVWR], count_field} : REQ.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST)
      lock_sticky <= 1'b0;
    else if (CE && byte25[`SCC_BIT_LOCK])
      lock_sticky <= 1'b1;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      nv_state <= scc_pkg::SCC_NV_IDLE;
      nv_cnt   <= '0;
    end else if (CE) begin
      case (nv_state)
        // A fresh edge in the cycle right after completion must not be lost
        scc_pkg::SCC_NV_IDLE, scc_pkg::SCC_NV_DONE: if (nv_start) begin
          nv_state <= scc_pkg::SCC_NV_PROG;
          nv_cnt   <= '0;
        end else begin
          nv_state <= scc_pkg::SCC_NV_IDLE;
        end
        scc_pkg::SCC_NV_PROG: if (nv_cnt == NV_LAST) begin
          nv_state <= scc_pkg::SCC_NV_DONE;
        end else begin
          nv_cnt <= nv_cnt + 1'b1;
        end
        default: nv_state <= scc_pkg::SCC_NV_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      NV_WRITE_IN_PROGRESS <= 1'b0;
      NV_PROG_STROBE       <= 1'b0;
    end else if (CE) begin
      NV_WRITE_IN_PROGRESS <= (nv_state == scc_pkg::SCC_NV_PROG) ? (nv_cnt != NV_LAST)
                              : nv_start;
      NV_PROG_STROBE       <= nv_start;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      SPREAD <= '0;
    end else if (CE) begin
      SPREAD.active <= (spread_amount_code != `SCC_SSC_BYPASS);
      SPREAD.center <= (spread_amount_code != `SCC_SSC_BYPASS) && !spread_amount_code[2];
      SPREAD.down   <= spread_amount_code[2];
      SPREAD.step   <= (spread_amount_code[2]) ? spread_amount_code[1:0]
                       : spread_amount_code[1:0] - 2'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RDATA             <= '0;
      BLOCK_READ_COUNT  <= 7'(`SCC_RST_B26);
      NV_PERMANENT_LOCK <= 1'b0;
      LOOP_BYPASS       <= 1'b0;
      MOD_FACTOR        <= '0;
      INPUT_SOURCE      <= `SCC_SRC_XTAL;
      SEL_REF_INPUT_B   <= 1'b0;
    end else if (CE) begin
      case (REQ.addr)
        `SCC_ADDR_B03: RDATA <= byte03;
        `SCC_ADDR_B10: RDATA <= byte10;
        `SCC_ADDR_B11: RDATA <= byte11;
        `SCC_ADDR_B24: RDATA <= {NV_WRITE_IN_PROGRESS, 7'h00};
        `SCC_ADDR_B25: RDATA <= byte25;
        `SCC_ADDR_B26: RDATA <= byte26;
        default:       RDATA <= 8'h00;
      endcase
      BLOCK_READ_COUNT  <= count_field;
      NV_PERMANENT_LOCK <= lock_sticky | byte25[`SCC_BIT_LOCK];
      LOOP_BYPASS       <= byte03[`SCC_BIT_BYPASS];
      MOD_FACTOR        <= factor_field;
      INPUT_SOURCE      <= src_field;
      // Pin select only matters in single-ended mode
      SEL_REF_INPUT_B   <= single_ended &&
                           ((pinsel_field == `SCC_PINSEL_CODE) ? SHARED_CONTROL_PIN
                                                               : byte10[`SCC_BIT_INSEL]);
    end
  end

  lock_stays_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CE && NV_PERMANENT_LOCK |=> NV_PERMANENT_LOCK)
    else $error("lock dropped");
  locked_no_prog_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    NV_PERMANENT_LOCK |-> !nv_start)
    else $error("program while locked");
  edge_only_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    nv_start |-> !byte26[`SCC_BIT_NVWR])
    else $error("start without edge");
  busy_rise_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CE && nv_start |=> NV_WRITE_IN_PROGRESS)
    else $error("busy not set");
  cmd_kept_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !wr_hit26 |=> byte26 == $past(byte26))
    else $error("command bit changed");
  count_nonzero_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    count_field != `SCC_CNT_ZERO)
    else $error("zero count");
  bypass_idle_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CE && spread_amount_code == 3'h0 |=> !SPREAD.active)
    else $error("spread not bypassed");
  down_spread_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CE && spread_amount_code[2] |=> SPREAD.down && !SPREAD.center)
    else $error("down spread wrong");
  strobe_single_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CE && NV_PROG_STROBE |=> !NV_PROG_STROBE)
    else $error("strobe longer than one cycle");
  busy_fall_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CE && nv_state == scc_pkg::SCC_NV_PROG && nv_cnt == NV_LAST |=> !NV_WRITE_IN_PROGRESS)
    else $error("busy not cleared");
  prog_writes_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    nv_state == scc_pkg::SCC_NV_PROG |=> $stable(byte25) && $stable(byte26))
    else $error("write taken while programming");
  center_spread_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CE && spread_amount_code != `SCC_SSC_BYPASS && !spread_amount_code[2]
    |=> SPREAD.center && SPREAD.active && SPREAD.step == 2'($past(spread_amount_code[1:0]) - 2'h1))
    else $error("center spread wrong");
  pin_select_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CE && single_ended && pinsel_field == `SCC_PINSEL_CODE
    |=> SEL_REF_INPUT_B == $past(SHARED_CONTROL_PIN))
    else $error("pin select ignored");
  bit_select_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CE && single_ended && pinsel_field != `SCC_PINSEL_CODE
    |=> SEL_REF_INPUT_B == $past(byte10[`SCC_BIT_INSEL]))
    else $error("select bit ignored");
  no_select_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CE && !single_ended |=> !SEL_REF_INPUT_B)
    else $error("select outside single-ended");
  lock_writes_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    wr_ok && lock_sticky && REQ.addr == `SCC_ADDR_B25 |=> byte25 == $past(REQ.wdata))
    else $error("write lost after lock");
  prog_cover_c: cover property (@(posedge CLK) nv_start);
  lock_cover_c: cover property (@(posedge CLK) lock_sticky && wr_hit26);
  pin_cover_c:  cover property (@(posedge CLK) pinsel_field == `SCC_PINSEL_CODE);
  busy_end_c:   cover property (@(posedge CLK) $fell(NV_WRITE_IN_PROGRESS));
  down_cover_c: cover property (@(posedge CLK) SPREAD.down);
endmodule : scc_cfg_regs

// *** verification/scc_host_model.sv ***
`timescale 1ns/1ps
module scc_host_model (
  input  wire logic         clk,
  input  wire logic [7:0]   rdata,
  output logic              req_valid,
  output scc_pkg::scc_req_s req
);
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end
  // Request held over exactly one rising edge, changed at falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req_valid = 1'b1;
    req       = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    req_valid = 1'b0;
    req.wdata = ~d; // Stale data never lingers on the bus
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req_valid = 1'b1;
    req       = '{wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk);
    d         = rdata;
    req_valid = 1'b0;
  endtask : rd
endmodule : scc_host_model

// *** verification/synth_config_eeprom_ctrl_tb.sv ***
`timescale 1ns/1ps
`include "scc_defs.svh"
module synth_config_eeprom_ctrl_tb;
  logic                 CLK, SYS_RST, REQ_VALID, SHARED_CONTROL_PIN, BUSY, STROBE, LOCK, BYPASS, SEL_B, CE;
  scc_pkg::scc_req_s    REQ;
  scc_pkg::scc_spread_s SPREAD;
  logic [7:0]           RDATA, rd_val;
  logic [6:0]           COUNT;
  logic [3:0]           MOD_FACTOR;
  logic [1:0]           INPUT_SOURCE;
  int                   n_fail, check_count, n_strobe, cycles;
  scc_cfg_regs scc_cfg_regs_i (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .SHARED_CONTROL_PIN(SHARED_CONTROL_PIN), .RDATA(RDATA), .BLOCK_READ_COUNT(COUNT),
    .NV_WRITE_IN_PROGRESS(BUSY), .NV_PROG_STROBE(STROBE), .NV_PERMANENT_LOCK(LOCK),
    .LOOP_BYPASS(BYPASS), .MOD_FACTOR(MOD_FACTOR), .SPREAD(SPREAD), .INPUT_SOURCE(INPUT_SOURCE),
    .SEL_REF_INPUT_B(SEL_B));
  scc_host_model scc_host_model_i (.clk(CLK), .rdata(RDATA), .req_valid(REQ_VALID), .req(REQ));
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (STROBE === 1'b1) n_strobe++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    scc_host_model_i.rd(a, rd_val);
    chk(rd_val & m, exp);
  endtask : rdchk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    scc_host_model_i.wr(a, d);
    // One more edge so the registered outputs show the write
    @(negedge CLK);
  endtask : wr
  // Loop is bypassed around every change of byte 25
  task automatic set_b25(input logic [7:0] v);
    wr(`SCC_ADDR_B03, 8'h40);
    chk({7'h0, BYPASS}, 8'h01);
    wr(`SCC_ADDR_B25, v);
    wr(`SCC_ADDR_B03, 8'h00);
    chk({7'h0, BYPASS}, 8'h00);
  endtask : set_b25
  initial begin
    SYS_RST = 1'b1;
    CE = 1'b1;
    SHARED_CONTROL_PIN = 1'b0;
    repeat (6) @(negedge CLK);
    SYS_RST = 1'b0;
    rdchk(`SCC_ADDR_B25, 8'hFF, 8'h09);
    rdchk(`SCC_ADDR_B26, 8'hFF, 8'h1B);
    chk({1'b0, COUNT}, 8'd27);
    chk({5'h0, INPUT_SOURCE, SEL_B}, 8'h00);
    chk({7'h0, LOCK}, 8'h00);
    for (int c = 0; c < 8; c++) begin
      set_b25({1'b0, 3'(c), 4'(c) ^ 4'hF});
      chk({5'h0, SPREAD.center, SPREAD.down, SPREAD.active}, {5'h0, c > 0 && c < 4, c > 3, c != 0});
      if (c != 0) chk({6'h0, SPREAD.step}, 8'((c < 4) ? c - 1 : c - 4));
      chk({4'h0, MOD_FACTOR}, {4'h0, 4'(c) ^ 4'hF});
    end
    wr(`SCC_ADDR_B26, 8'h00);
    chk({1'b0, COUNT}, 8'd27);
    wr(`SCC_ADDR_B26, 8'h7F);
    chk({1'b0, COUNT}, 8'd127);
    wr(`SCC_ADDR_B26, 8'h05);
    wr(`SCC_ADDR_B26, 8'h85);
    chk({7'h0, BUSY}, 8'h01);
    rdchk(`SCC_ADDR_B24, 8'h80, 8'h80);
    // Host stays off the write path until programming ends
    repeat (900) if (BUSY === 1'b1) @(negedge CLK);
    chk({7'h0, BUSY}, 8'h00);
    rdchk(`SCC_ADDR_B26, 8'hFF, 8'h85);
    wr(`SCC_ADDR_B24, 8'h80);
    rdchk(`SCC_ADDR_B24, 8'h80, 8'h00);
    wr(`SCC_ADDR_B26, 8'h85);
    chk(8'(n_strobe), 8'h01);
    set_b25(8'h80);
    chk({7'h0, LOCK}, 8'h01);
    set_b25(8'h09);
    chk({7'h0, LOCK}, 8'h01);
    chk({4'h0, MOD_FACTOR}, 8'h09);
    wr(`SCC_ADDR_B26, 8'h05);
    wr(`SCC_ADDR_B26, 8'h85);
    chk({7'h0, BUSY}, 8'h00);
    chk(8'(n_strobe), 8'h01);
    wr(`SCC_ADDR_B11, 8'hC0);
    chk({6'h0, INPUT_SOURCE}, 8'h03);
    wr(`SCC_ADDR_B11, 8'h40);
    wr(`SCC_ADDR_B10, 8'h10);
    chk({7'h0, SEL_B}, 8'h01);
    SHARED_CONTROL_PIN = 1'b1;
    wr(`SCC_ADDR_B10, 8'h01);
    chk({7'h0, SEL_B}, 8'h01);
    SHARED_CONTROL_PIN = 1'b0;
    repeat (2) @(negedge CLK);
    chk({7'h0, SEL_B}, 8'h00);
    CE = 1'b0;
    wr(`SCC_ADDR_B11, 8'h80);
    CE = 1'b1;
    @(negedge CLK);
    chk({6'h0, INPUT_SOURCE}, 8'h01);
    rdchk(8'h40, 8'hFF, 8'h00);
    results();
  end
endmodule : synth_config_eeprom_ctrl_tb
